//--- common/asc_if.sv
/*
  link wires between the serial master and the converter port.
  the output enables go only to the link checker; the host reads the lines as driven.
*/
interface asc_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic serial_out_a;
   logic serial_out_a_oe_n;
   logic serial_out_b;
   logic serial_out_b_oe_n;

   modport dev (
      input  cs_n,
      input  sclk,
      input  sdi,
      output serial_out_a,
      output serial_out_a_oe_n,
      output serial_out_b,
      output serial_out_b_oe_n
   );

   modport host (
      output cs_n,
      output sclk,
      output sdi,
      input  serial_out_a,
      input  serial_out_b
   );
endinterface

//--- common/asc_pkg.sv
/*
  shared constants, command layout and checksum function for the serial
  register access link. assumes a 100 MHz pclk on both ends.
*/
package asc_pkg;
   // command frame layout
   localparam int         ASC_WR_BIT      = 15;
   localparam int         ASC_ADDR_HI     = 14;
   localparam int         ASC_ADDR_LO     = 12;
   localparam logic [5:0] ASC_CMD_LEN     = 6'h10;
   localparam logic [5:0] ASC_CRC_LEN     = 6'h18;
   localparam logic [5:0] ASC_CNT_MAX     = 6'h3f;
   localparam int         ASC_A_SR_W      = 44;
   localparam int         ASC_B_SR_W      = 18;
   // register addresses
   localparam logic [2:0] ASC_A_SETUP1    = 3'h1;
   localparam logic [2:0] ASC_A_SETUP2    = 3'h2;
   localparam logic [2:0] ASC_A_STATUS    = 3'h3;
   localparam logic [2:0] ASC_A_THR_LO    = 3'h4;
   localparam logic [2:0] ASC_A_THR_HI    = 3'h5;
   // field positions
   localparam int         ASC_CRC_W_BIT   = 5;
   localparam int         ASC_CRC_R_BIT   = 4;
   localparam int         ASC_RES_BIT     = 2;
   localparam int         ASC_ONE_WIRE_BIT = 8;
   // reset values
   localparam logic [11:0] ASC_RST_SETUP  = 12'h000;
   localparam logic [11:0] ASC_RST_THR_LO = 12'h800;
   localparam logic [11:0] ASC_RST_THR_HI = 12'h7ff;
   // checksum
   localparam logic [8:0] ASC_POLY        = 9'h107;
   localparam logic [7:0] ASC_TOP_INV     = 8'hff;
   // host timing
   localparam int         ASC_CLK_MHZ     = 100;
   localparam int         ASC_HALF_NS     = 80;
   localparam int         ASC_GAP_NS      = 40;
   localparam int         ASC_HALF_CYC    = (ASC_HALF_NS * ASC_CLK_MHZ + 999) / 1000;
   localparam int         ASC_GAP_CYC     = (ASC_GAP_NS * ASC_CLK_MHZ + 999) / 1000;
   localparam logic [3:0] ASC_HALF_TMR    = 4'(ASC_HALF_CYC - 1);
   localparam logic [3:0] ASC_GAP_TMR     = 4'(ASC_GAP_CYC - 1);
   // host apb map
   localparam logic [7:0] ASC_OFF_CTRL    = 8'h00;
   localparam logic [7:0] ASC_OFF_TX      = 8'h04;
   localparam logic [7:0] ASC_OFF_STAT    = 8'h08;
   localparam logic [7:0] ASC_OFF_RXA_LO  = 8'h0c;
   localparam logic [7:0] ASC_OFF_RXA_HI  = 8'h10;
   localparam logic [7:0] ASC_OFF_RXB     = 8'h14;
   localparam int         ASC_START_BIT   = 31;
   localparam int         ASC_APPEND_BIT  = 8;

   // remainder of (data with top byte inverted) * x^8 over the polynomial
   function automatic logic [7:0] asc_crc8(input logic [31:0] d, input logic wide);
      logic [31:0] v;
      logic [7:0]  c;
      int          i;
      int          n;
      v = wide ? (d ^ {ASC_TOP_INV, 24'h000000})
               : {d[15:0] ^ {ASC_TOP_INV, 8'h00}, 16'h0000};
      n = wide ? 32 : 16;
      c = 8'h00;
      for (i = 31; i >= 32 - n; i--)
      begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? ASC_POLY[7:0] : 8'h00);
      end
      return c;
   endfunction
endpackage

//--- design/asc_dev.sv
/*
  converter side of the serial port: command decode, register file,
  readback framing and checksums. assumes the link pins are asynchronous
  to pclk and that sclk half periods last at least five pclk cycles.
*/
module asc_dev
   import asc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   asc_if.dev               link,
   input  wire logic [17:0] conv_a,
   input  wire logic [17:0] conv_b,
   input  wire logic        conv_valid,
   input  wire logic [11:0] status_word,
   output logic             conv_start,
   output logic [11:0]      setup1_word,
   output logic [11:0]      setup2_word,
   output logic             write_crc_error
);
   logic [2:0]            cs_s_q;
   logic [2:0]            ck_s_q;
   logic [2:0]            di_s_q;
   logic                  cs_fall;
   logic                  cs_rise;
   logic                  ck_rise;
   logic                  di;
   logic [11:0]           setup1_q, setup1_d;
   logic [11:0]           setup2_q, setup2_d;
   logic [11:0]           thr_lo_q, thr_lo_d;
   logic [11:0]           thr_hi_q, thr_hi_d;
   logic [17:0]           res_a_q, res_a_d;
   logic [17:0]           res_b_q, res_b_d;
   logic [ASC_A_SR_W-1:0] a_sr_q, a_sr_d;
   logic [ASC_B_SR_W-1:0] b_sr_q, b_sr_d;
   logic [15:0]           in_sr_q, in_sr_d;
   logic [15:0]           cmd_q, cmd_d;
   logic [7:0]            crc_in_q, crc_in_d;
   logic [5:0]            cnt_q, cnt_d;
   logic                  pend_q, pend_d;
   logic [2:0]            pend_addr_q, pend_addr_d;
   logic                  oe_n_q, oe_n_d;
   logic                  start_q, start_d;
   logic                  err_q, err_d;

   // three stages per pin: two to synchronise, one for edge detection on cs_n and sclk; sdi is taken from the second stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cs_s_q <= 3'h7;
         ck_s_q <= 3'h0;
         di_s_q <= 3'h0;
      end
      else
      begin
         cs_s_q <= {cs_s_q[1:0], link.cs_n};
         ck_s_q <= {ck_s_q[1:0], link.sclk};
         di_s_q <= {di_s_q[1:0], link.sdi};
      end
   end

   // edges seen only after the second stage, never on the first
   assign cs_fall = cs_s_q[2] & ~cs_s_q[1];
   assign cs_rise = ~cs_s_q[2] & cs_s_q[1];
   assign ck_rise = ~ck_s_q[2] & ck_s_q[1] & ~cs_s_q[1];
   assign di      = di_s_q[1];

   // register contents for a pending readback
   function automatic logic [11:0] read_mux(input logic [2:0] a, input logic [11:0] s1,
                                            input logic [11:0] s2, input logic [11:0] st,
                                            input logic [11:0] lo, input logic [11:0] hi);
      case (a)
         ASC_A_SETUP1: read_mux = s1;
         ASC_A_SETUP2: read_mux = s2;
         ASC_A_STATUS: read_mux = st;
         ASC_A_THR_LO: read_mux = lo;
         ASC_A_THR_HI: read_mux = hi;
         default:      read_mux = 12'h000;
      endcase
   endfunction

   // frame engine: load at select fall, shift on sclk, decode at select rise
   always_comb
   begin
      logic [15:0] a16;
      logic [15:0] b16;
      logic [15:0] rd;
      logic [7:0]  crc;
      logic        one;
      logic        res;
      logic        ok;
      logic [2:0]  addr;
      a16         = res_a_q[17:2];
      b16         = res_b_q[17:2];
      rd          = 16'h0000;
      crc         = 8'h00;
      one         = setup2_q[ASC_ONE_WIRE_BIT];
      res         = setup1_q[ASC_RES_BIT];
      ok          = 1'b0;
      addr        = cmd_q[ASC_ADDR_HI:ASC_ADDR_LO];
      setup1_d    = setup1_q;
      setup2_d    = setup2_q;
      thr_lo_d    = thr_lo_q;
      thr_hi_d    = thr_hi_q;
      res_a_d     = res_a_q;
      res_b_d     = res_b_q;
      a_sr_d      = a_sr_q;
      b_sr_d      = b_sr_q;
      in_sr_d     = in_sr_q;
      cmd_d       = cmd_q;
      crc_in_d    = crc_in_q;
      cnt_d       = cnt_q;
      pend_d      = pend_q;
      pend_addr_d = pend_addr_q;
      oe_n_d      = oe_n_q;
      start_d     = cs_fall;
      err_d       = 1'b0;
      // a finished conversion replaces the held result; a frame opened
      // before it finishes still shows the older one
      if (conv_valid)
      begin
         res_a_d = conv_a;
         res_b_d = conv_b;
      end
      if (cs_fall)
      begin
         oe_n_d = 1'b0;
         cnt_d  = 6'h00;
         pend_d = 1'b0;
         if (pend_q)
         begin
            rd = {1'b0, pend_addr_q, read_mux(pend_addr_q, setup1_q, setup2_q,
                                              status_word, thr_lo_q, thr_hi_q)};
            if (setup1_q[ASC_CRC_R_BIT])
            begin
               crc = asc_crc8({16'h0000, rd}, 1'b0);
            end
            a_sr_d = {rd, crc, 20'h00000};
            b_sr_d = 18'h00000;
         end
         else
         begin
            if (setup1_q[ASC_CRC_R_BIT])
            begin
               crc = asc_crc8({a16, b16}, 1'b1);
            end
            // checksum always follows the last data bit on line a
            case ({one, res})
               2'b00:   a_sr_d = {a16, crc, 20'h00000};
               2'b01:   a_sr_d = {res_a_q, crc, 18'h00000};
               2'b10:   a_sr_d = {a16, b16, crc, 4'h0};
               2'b11:   a_sr_d = {res_a_q, res_b_q, crc};
               default: a_sr_d = '0;
            endcase
            b_sr_d = one ? 18'h00000 : (res ? res_b_q : {b16, 2'b00});
         end
      end
      else if (ck_rise)
      begin
         a_sr_d  = {a_sr_q[ASC_A_SR_W-2:0], 1'b0};
         b_sr_d  = {b_sr_q[ASC_B_SR_W-2:0], 1'b0};
         in_sr_d = {in_sr_q[14:0], di};
         if (cnt_q != ASC_CNT_MAX)
         begin
            cnt_d = cnt_q + 6'h01;
         end
         if (cnt_q == ASC_CMD_LEN - 6'h01)
         begin
            cmd_d = {in_sr_q[14:0], di};
         end
         if (cnt_q == ASC_CRC_LEN - 6'h01)
         begin
            crc_in_d = {in_sr_q[6:0], di};
         end
      end
      if (cs_rise)
      begin
         oe_n_d = 1'b1;
         if (cnt_q >= ASC_CMD_LEN)
         begin
            ok = (cnt_q == ASC_CRC_LEN) &&
                 (crc_in_q == asc_crc8({16'h0000, cmd_q}, 1'b0));
            if (!cmd_q[ASC_WR_BIT])
            begin
               // low twelve bits ignored; unlisted addresses fall back
               pend_d      = (addr >= ASC_A_SETUP1) && (addr <= ASC_A_THR_HI);
               pend_addr_d = addr;
            end
            else
            begin
               if (setup1_q[ASC_CRC_W_BIT])
               begin
                  err_d = ~ok;
               end
               else if (cnt_q == ASC_CMD_LEN)
               begin
                  // a plain 16-bit frame may not turn write checksum on
                  ok = !((addr == ASC_A_SETUP1) && cmd_q[ASC_CRC_W_BIT]);
               end
               if (ok)
               begin
                  case (addr)
                     ASC_A_SETUP1: setup1_d = cmd_q[11:0];
                     ASC_A_SETUP2: setup2_d = cmd_q[11:0];
                     ASC_A_THR_LO: thr_lo_d = cmd_q[11:0];
                     ASC_A_THR_HI: thr_hi_d = cmd_q[11:0];
                     default:      setup1_d = setup1_q;
                  endcase
               end
            end
         end
      end
   end

   // frame engine registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         setup1_q    <= ASC_RST_SETUP;
         setup2_q    <= ASC_RST_SETUP;
         thr_lo_q    <= ASC_RST_THR_LO;
         thr_hi_q    <= ASC_RST_THR_HI;
         res_a_q     <= 18'h00000;
         res_b_q     <= 18'h00000;
         a_sr_q      <= '0;
         b_sr_q      <= '0;
         in_sr_q     <= 16'h0000;
         cmd_q       <= 16'h0000;
         crc_in_q    <= 8'h00;
         cnt_q       <= 6'h00;
         pend_q      <= 1'b0;
         pend_addr_q <= 3'h0;
         oe_n_q      <= 1'b1;
         start_q     <= 1'b0;
         err_q       <= 1'b0;
      end
      else
      begin
         setup1_q    <= setup1_d;
         setup2_q    <= setup2_d;
         thr_lo_q    <= thr_lo_d;
         thr_hi_q    <= thr_hi_d;
         res_a_q     <= res_a_d;
         res_b_q     <= res_b_d;
         a_sr_q      <= a_sr_d;
         b_sr_q      <= b_sr_d;
         in_sr_q     <= in_sr_d;
         cmd_q       <= cmd_d;
         crc_in_q    <= crc_in_d;
         cnt_q       <= cnt_d;
         pend_q      <= pend_d;
         pend_addr_q <= pend_addr_d;
         oe_n_q      <= oe_n_d;
         start_q     <= start_d;
         err_q       <= err_d;
      end
   end

   // pins and user side, all from flops
   assign link.serial_out_a      = a_sr_q[ASC_A_SR_W-1];
   assign link.serial_out_b      = b_sr_q[ASC_B_SR_W-1];
   assign link.serial_out_a_oe_n = oe_n_q;
   assign link.serial_out_b_oe_n = oe_n_q;
   assign conv_start             = start_q;
   assign setup1_word            = setup1_q;
   assign setup2_word            = setup2_q;
   assign write_crc_error        = err_q;
endmodule

//--- design/asc_host.sv
/*
  serial master with an apb register port. software loads a frame,
  starts it and reads back what both output lines returned.
  assumes the device answers within five pclk cycles of each sclk rise.
*/
module asc_host
   import asc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   asc_if.host              link
);
   typedef enum logic [2:0] {
      ASC_S_IDLE = 3'h0,
      ASC_S_LEAD = 3'h1,
      ASC_S_HI   = 3'h2,
      ASC_S_LO   = 3'h3,
      ASC_S_TAIL = 3'h4,
      ASC_S_GAP  = 3'h5
   } asc_state_type;

   asc_state_type state_q, state_d;
   logic [1:0]    sa_s_q;
   logic [1:0]    sb_s_q;
   logic [3:0]    tmr_q, tmr_d;
   logic [5:0]    bits_q, bits_d;
   logic [5:0]    len_q, len_d;
   logic [23:0]   tx_q, tx_d;
   logic [23:0]   sh_q, sh_d;
   logic [43:0]   rxa_q, rxa_d;
   logic [17:0]   rxb_q, rxb_d;
   logic          cs_q, cs_d;
   logic          ck_q, ck_d;
   logic          di_q, di_d;
   logic [31:0]   rd_q, rd_d;
   logic          mapped;
   logic          wr_en;

   assign mapped = (paddr == ASC_OFF_CTRL) || (paddr == ASC_OFF_TX) ||
                   (paddr == ASC_OFF_STAT) || (paddr == ASC_OFF_RXA_LO) ||
                   (paddr == ASC_OFF_RXA_HI) || (paddr == ASC_OFF_RXB);
   assign wr_en  = psel & penable & pwrite & mapped;

   // returned lines pass two flops before sampling
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sa_s_q <= 2'h0;
         sb_s_q <= 2'h0;
      end
      else
      begin
         sa_s_q <= {sa_s_q[0], link.serial_out_a};
         sb_s_q <= {sb_s_q[0], link.serial_out_b};
      end
   end

   // frame sequencer and apb writes; sampling just before each rise
   // leaves the device a whole sclk period to answer
   always_comb
   begin
      state_d = state_q;
      tmr_d   = (tmr_q != 4'h0) ? tmr_q - 4'h1 : tmr_q;
      bits_d  = bits_q;
      len_d   = len_q;
      tx_d    = tx_q;
      sh_d    = sh_q;
      rxa_d   = rxa_q;
      rxb_d   = rxb_q;
      cs_d    = cs_q;
      ck_d    = ck_q;
      di_d    = di_q;
      if (wr_en && (paddr == ASC_OFF_TX))
      begin
         tx_d = pwdata[23:0];
      end
      case (state_q)
         ASC_S_IDLE:
         begin
            // start ignored while a frame runs or length is zero
            if (wr_en && (paddr == ASC_OFF_CTRL) && pwdata[ASC_START_BIT] &&
                (pwdata[5:0] != 6'h00))
            begin
               len_d = pwdata[5:0];
               sh_d  = pwdata[ASC_APPEND_BIT] ?
                       {tx_q[23:8], asc_crc8({16'h0000, tx_q[23:8]}, 1'b0)} : tx_q;
               di_d    = sh_d[23];
               cs_d    = 1'b0;
               bits_d  = 6'h00;
               rxa_d   = 44'h0;
               rxb_d   = 18'h0;
               tmr_d   = ASC_HALF_TMR;
               state_d = ASC_S_LEAD;
            end
         end
         ASC_S_LEAD, ASC_S_LO:
         begin
            if (tmr_q == 4'h0)
            begin
               ck_d    = 1'b1;
               rxa_d   = {rxa_q[42:0], sa_s_q[1]};
               rxb_d   = {rxb_q[16:0], sb_s_q[1]};
               bits_d  = bits_q + 6'h01;
               tmr_d   = ASC_HALF_TMR;
               state_d = ASC_S_HI;
            end
         end
         ASC_S_HI:
         begin
            if (tmr_q == 4'h0)
            begin
               ck_d    = 1'b0;
               sh_d    = {sh_q[22:0], 1'b0};
               di_d    = sh_q[22];
               tmr_d   = ASC_HALF_TMR;
               state_d = (bits_q == len_q) ? ASC_S_TAIL : ASC_S_LO;
            end
         end
         ASC_S_TAIL:
         begin
            if (tmr_q == 4'h0)
            begin
               cs_d    = 1'b1;
               tmr_d   = ASC_GAP_TMR;
               state_d = ASC_S_GAP;
            end
         end
         ASC_S_GAP:
         begin
            if (tmr_q == 4'h0)
            begin
               state_d = ASC_S_IDLE;
            end
         end
         default: state_d = ASC_S_IDLE;
      endcase
   end

   // read data captured in the setup cycle, valid through the access
   always_comb
   begin
      rd_d = rd_q;
      if (psel && !penable)
      begin
         case (paddr)
            ASC_OFF_CTRL:   rd_d = {26'h0, len_q};
            ASC_OFF_TX:     rd_d = {8'h00, tx_q};
            ASC_OFF_STAT:   rd_d = {18'h0, bits_q, 7'h00, state_q != ASC_S_IDLE};
            ASC_OFF_RXA_LO: rd_d = rxa_q[31:0];
            ASC_OFF_RXA_HI: rd_d = {20'h0, rxa_q[43:32]};
            ASC_OFF_RXB:    rd_d = {14'h0, rxb_q};
            default:        rd_d = 32'h0;
         endcase
      end
   end

   // sequencer and apb registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ASC_S_IDLE;
         tmr_q   <= 4'h0;
         bits_q  <= 6'h00;
         len_q   <= 6'h00;
         tx_q    <= 24'h0;
         sh_q    <= 24'h0;
         rxa_q   <= 44'h0;
         rxb_q   <= 18'h0;
         cs_q    <= 1'b1;
         ck_q    <= 1'b0;
         di_q    <= 1'b0;
         rd_q    <= 32'h0;
      end
      else
      begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
         bits_q  <= bits_d;
         len_q   <= len_d;
         tx_q    <= tx_d;
         sh_q    <= sh_d;
         rxa_q   <= rxa_d;
         rxb_q   <= rxb_d;
         cs_q    <= cs_d;
         ck_q    <= ck_d;
         di_q    <= di_d;
         rd_q    <= rd_d;
      end
   end

   // zero-wait slave; unmapped offsets flag an error
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~mapped;
   assign prdata    = rd_q;
   assign link.cs_n = cs_q;
   assign link.sclk = ck_q;
   assign link.sdi  = di_q;
endmodule

//--- verification/adc_serial_register_access_crc_test.sv
/*
  self-checking bench: apb drives the host end, which faces the device end.
  assumes a 100 MHz pclk and a converter stand-in answering conv_start.
*/
module adc_serial_register_access_crc_test
   import asc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, pready, pslverr, conv_start, write_crc_error, e;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_valid = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, ra, rh, rb, s, st;
   logic [17:0] conv_a = 18'h0, conv_b = 18'h0;
   logic [11:0] status_word = 12'h000, setup1_word, setup2_word, d, lo;
   logic [2:0]  a;
   int          failures, checked, errs;
   logic        ap = 1'b0;
   asc_if lnk ();
   asc_host asc_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(lnk));
   asc_dev asc_dev_inst (.pclk(pclk), .presetn(presetn), .link(lnk), .conv_a(conv_a),
      .conv_b(conv_b), .conv_valid(conv_valid), .status_word(status_word),
      .conv_start(conv_start), .setup1_word(setup1_word), .setup2_word(setup2_word),
      .write_crc_error(write_crc_error));
   asc_link_chk asc_link_chk_inst (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n),
      .sclk(lnk.sclk), .sdi(lnk.sdi), .serial_out_a(lnk.serial_out_a),
      .serial_out_a_oe_n(lnk.serial_out_a_oe_n), .serial_out_b(lnk.serial_out_b),
      .serial_out_b_oe_n(lnk.serial_out_b_oe_n));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // converter stand-in: fresh result right after each start
   always @(posedge pclk)
   begin
      conv_valid <= conv_start;
      if (conv_start === 1'b1)
      begin
         conv_a <= 18'($urandom);
         conv_b <= 18'($urandom);
      end
   end
   always @(posedge pclk) if (write_crc_error === 1'b1) errs++;

   task results();
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [39:0] x, input logic [39:0] y);
      checked++;
      if (y !== x)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, x, y);
      end
   endtask
   // remainder by repeated subtraction, top byte inverted
   function automatic logic [7:0] crc(input logic [31:0] v, input int n);
      logic [39:0] t;
      t = {v ^ (32'hff << (n - 8)), 8'h00};
      for (int i = n + 7; i >= 8; i--)
         if (t[i])
            t[i -: 9] = t[i -: 9] ^ ASC_POLY;
      return t[7:0];
   endfunction
   function automatic logic [39:0] line_a(input int n);
      return {rh[7:0], ra} & ((40'h1 << n) - 40'h1);
   endfunction
   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] r, output logic er);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 20)
      begin
         @(posedge pclk);
         i++;
      end
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never reassigns psel in this step
      @(posedge pclk);
      if (i >= 20)
      begin
         failures++;
         results();
      end
   endtask
   // one frame, then fetch both captured lines
   task automatic frm(input logic [23:0] tx, input logic [5:0] n);
      int i;
      apb(1'b1, ASC_OFF_TX, {8'h00, tx}, s, e);
      apb(1'b1, ASC_OFF_CTRL, {1'b1, 22'h0, ap, 2'h0, n}, s, e);
      s = 32'h1;
      for (i = 0; i < 1000 && s[0] !== 1'b0; i++)
         apb(1'b0, ASC_OFF_STAT, 32'h0, s, e);
      if (i >= 1000)
      begin
         failures++;
         results();
      end
      apb(1'b0, ASC_OFF_RXA_LO, 32'h0, ra, e);
      apb(1'b0, ASC_OFF_RXA_HI, 32'h0, rh, e);
      apb(1'b0, ASC_OFF_RXB, 32'h0, rb, e);
   endtask
   task automatic rdreg(input logic [2:0] ad, input logic [11:0] v, input logic cr);
      logic [15:0] w;
      w = {1'b0, ad, v};
      frm({1'b0, ad, 12'($urandom), 8'h00}, 6'h10);
      frm(24'h000000, cr ? 6'h18 : 6'h10);
      chk("register", cr ? {16'h0, w, crc({16'h0, w}, 16)} : {24'h0, w}, line_a(cr ? 24 : 16));
   endtask
   // m: 0 plain, 1 good checksum, 2 bad checksum, 3 checksum added by the host
   task automatic wr(input logic [2:0] ad, input logic [11:0] v, input logic [1:0] m);
      logic [15:0] w;
      logic [7:0]  c;
      w = {1'b1, ad, v};
      c = (m == 2'h1 || m == 2'h2) ? crc({16'h0, w}, 16) ^ {7'h0, m[1]} : 8'h00;
      ap = (m == 2'h3);
      frm({w, c}, m == 2'h0 ? 6'h10 : 6'h18);
      ap = 1'b0;
   endtask
   // capture on line a (b = 0) or line b (b = 1) after a conversion frame of n clocks
   function automatic logic [39:0] conv_exp(input logic [5:0] n, input logic [17:0] ca,
                                            input logic [17:0] cb, input logic b);
      logic [31:0] x;
      x = {ca[17:2], cb[17:2]};
      if (b)
         return n == 6'h10 ? {24'h0, x[15:0]} : n == 6'h18 ? {22'h0, x[9:0], 8'h00} :
                n == 6'h1a ? {22'h0, cb[9:0], 8'h00} : 40'h0;
      return n == 6'h28 ? {x, crc(x, 32)} : n == 6'h1a ? {14'h0, ca, crc(x, 32)} :
             n == 6'h18 ? {16'h0, x[31:16], crc(x, 32)} : {24'h0, x[31:16]};
   endfunction
   // result expected is the one converted during the previous frame
   task automatic cnv(input logic [5:0] n);
      logic [17:0] ca;
      logic [17:0] cb;
      ca = conv_a;
      cb = conv_b;
      frm(24'h000000, n);
      chk("conv_a", conv_exp(n, ca, cb, 1'b0), line_a(n));
      chk("conv_b", conv_exp(n, ca, cb, 1'b1), {22'h0, rb[17:0]});
   endtask

   initial
   begin
      void'($urandom(32'h9106));
      st = $urandom;
      status_word <= st[11:0];
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'h3c, 32'h0, s, e);
      chk("unmapped", 40'h1, {39'h0, e});
      rdreg(ASC_A_THR_LO, ASC_RST_THR_LO, 1'b0);
      rdreg(ASC_A_THR_HI, ASC_RST_THR_HI, 1'b0);
      wr(ASC_A_STATUS, ~st[11:0], 2'h0);
      rdreg(ASC_A_STATUS, st[11:0], 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         d = 12'($urandom);
         a = i[0] ? ASC_A_THR_HI : ASC_A_THR_LO;
         lo = i[0] ? lo : d;
         wr(a, d, 2'h0);
         rdreg(a, d, 1'b0);
      end
      for (int i = 0; i < 8; i++)
      begin
         if (i == 0 || i == 6 || i == 7)
         begin
            frm({4'(i), 12'hfff, 8'h00}, 6'h10);
            cnv(6'h10);
         end
      end
      wr(ASC_A_SETUP1, 12'h030, 2'h0);
      chk("setup1", 40'h0, {28'h0, setup1_word});
      wr(ASC_A_SETUP1, 12'h030, 2'h1);
      chk("setup1", 40'h30, {28'h0, setup1_word});
      wr(ASC_A_THR_LO, 12'h123, 2'h0);
      wr(ASC_A_SETUP1, 12'h010, 2'h2);
      chk("dropped", 40'h2, 40'(errs));
      chk("setup1", 40'h30, {28'h0, setup1_word});
      rdreg(ASC_A_THR_LO, lo, 1'b1);
      wr(ASC_A_THR_HI, 12'h5a5, 2'h3);
      rdreg(ASC_A_THR_HI, 12'h5a5, 1'b1);
      cnv(6'h18);
      wr(ASC_A_SETUP2, 12'h100, 2'h1);
      chk("setup2", 40'h100, {28'h0, setup2_word});
      cnv(6'h28);
      wr(ASC_A_SETUP1, 12'h010, 2'h1);
      chk("setup1", 40'h10, {28'h0, setup1_word});
      wr(ASC_A_SETUP2, 12'h000, 2'h0);
      cnv(6'h18);
      wr(ASC_A_SETUP1, 12'h014, 2'h0);
      cnv(6'h1a);
      results();
   end
endmodule

//--- verification/asc_link_chk.sv
/*
  link checker for the serial register access pair.
  assumes it watches the interface wires between host and device ends.
*/
module asc_link_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic serial_out_a,
   input wire logic serial_out_a_oe_n,
   input wire logic serial_out_b,
   input wire logic serial_out_b_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // one high phase of eight pclk, then low
   sequence s_high_phase;
      sclk [*8] ##1 !sclk;
   endsequence
   // select low, clock parked for the lead time
   sequence s_lead;
      (!cs_n && !sclk) [*8];
   endsequence

   property p_half; $rose(sclk) |-> s_high_phase; endproperty
   property p_lead; $fell(cs_n) |-> s_lead; endproperty
   property p_park; cs_n |-> !sclk; endproperty
   property p_sdi_hold; sclk |-> $stable(sdi); endproperty
   property p_first; $fell(cs_n) |-> ##[2:5] !serial_out_a_oe_n; endproperty
   property p_release;
      $rose(cs_n) |-> ##[1:6] (serial_out_a_oe_n && serial_out_b_oe_n);
   endproperty
   // late in the high phase the device bit has settled
   property p_out_hold;
      (!cs_n && sclk && $past(sclk, 5)) |-> ($stable(serial_out_a) && $stable(serial_out_b));
   endproperty
   property p_gap; $rose(cs_n) |-> cs_n [*4]; endproperty

   a_half: assert property (p_half) else $error("sclk high phase wrong");
   a_lead: assert property (p_lead) else $error("select lead wrong");
   a_park: assert property (p_park) else $error("sclk runs outside frame");
   a_sdi_hold: assert property (p_sdi_hold) else $error("sdi moved while sclk high");
   a_first: assert property (p_first) else $error("line a not driven");
   a_release: assert property (p_release) else $error("lines not released");
   a_out_hold: assert property (p_out_hold) else $error("output bit moved");
   a_gap: assert property (p_gap) else $error("frame gap too short");
endmodule
